//--- acq_regs_pkg.sv
// Package holding offsets, fields, reset values and carriers of the bank.
package acq_regs_pkg;

	// ----------------------------------------------------------------
	// Register indices and address width
	// ----------------------------------------------------------------
	localparam logic [7:0] RES_HI_WIDE_IDX = 8'h68;
	localparam logic [7:0] RES_HI_IDX = 8'h69;
	localparam logic [7:0] RES_LO_IDX = 8'h6A;
	localparam logic [7:0] VOLTAGE_RESULT_IDX = 8'h6C;
	localparam logic [7:0] COEF_CNT_IDX = 8'h6E;
	localparam logic [7:0] TRIG_PERIOD_IDX = 8'h70;
	localparam logic [7:0] WAKE_FILT_IDX = 8'h72;
	localparam logic [7:0] CHOP_MASK_IDX = 8'h74;
	localparam logic [7:0] CHOP_CTRL_IDX = 8'h75;
	localparam logic [7:0] CTRL_IDX = 8'h80;
	localparam logic [7:0] STATUS_IDX = 8'h81;
	localparam int ADDR_W = 10;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int HOLD_LSB = 4;
	localparam int IIR_LSB = 1;
	localparam int FAST_BIT = 0;
	localparam int COEF_CNT_W = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] COEF_CNT_RST = 4'hE;
	localparam logic [15:0] TRIG_PERIOD_RST = 16'h0000;
	localparam logic [7:0] WAKE_FILT_RST = 8'h00;
	localparam logic [1:0] HOLD_RST = 2'h0;
	localparam logic [2:0] IIR_RST = 3'h7;
	localparam logic FAST_RST = 1'b1;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] swap_hold_time;
		logic [2:0] iir_coefficient_select;
		logic amp_fast_mode;
	} chopper_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [23:0] current_result;
		logic [15:0] voltage_result;
	} sample_t;

endpackage

//--- acquisition_result_register_bank.sv
// Acquisition result register bank with an AXI4-Lite slave port.
//
// The AXI4-Lite register port was decided locally.
module acquisition_result_register_bank
	import acq_regs_pkg::*;
#(
	parameter int TRIG_W = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// AXI4-Lite write address, data and response.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Conversion results from the datapath.
	input wire sample_t sample_in,
	// Low-power clock tick and mode, synchronous to core_clk.
	input wire logic lowpower_clock,
	input wire logic lowpower_mode,
	// Control outputs toward the datapath.
	output logic [COEF_CNT_W-1:0] filter_coefficient_count,
	output logic [7:0] threshold_wakeup_filter_period,
	output chopper_ctrl_t chopper_ctrl,
	output logic [2:0] swap_hold_periods,
	output logic acquisition_start
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte address to register index.
	function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[9:2];
	endfunction

	// Hold code to periods of the 64 kHz clock.
	function automatic logic [2:0] hold_periods(input logic [1:0] c);
		hold_periods = (c == 2'h0) ? 3'h0 : {1'b0, c} + 3'h2;
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [23:0] cur_res_r;
	logic [15:0] voltage_result_r;
	logic [15:0] lo_snap_r;
	logic [COEF_CNT_W-1:0] coef_cnt_r;
	logic [TRIG_W-1:0] period_r;
	logic [TRIG_W-1:0] trig_cnt_r;
	logic [7:0] wake_filt_r;
	logic [5:0] mask_r;
	chopper_ctrl_t chop_r;
	logic start_r;
	logic byte_err_r;
	logic [7:0] start_cnt_r;

	// Write channel handshake state.
	logic [ADDR_W-1:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic wr_fire;
	logic [7:0] wr_idx;
	logic wr_wide;
	logic wr_ok;

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	// Address and data may arrive in either order and are latched.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_r <= 1'b0;
		end
	end

	// Ready drops once each side is held, until the response is taken.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_bvalid &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_have_r && !s_axi_bvalid &&
				!(s_axi_wvalid && s_axi_wready);
		end
	end

	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_idx = idx_of(aw_addr_r);
	assign wr_wide = (w_strb_r[1:0] == 2'h3);

	// Only documented writable registers accept writes.
	always_comb begin
		case (wr_idx)
			COEF_CNT_IDX, WAKE_FILT_IDX, CHOP_MASK_IDX, CHOP_CTRL_IDX:
				wr_ok = w_strb_r[0];
			TRIG_PERIOD_IDX: wr_ok = wr_wide;
			CTRL_IDX: wr_ok = w_strb_r[0];
			default: wr_ok = 1'b0;
		endcase
	end

	// Write response one cycle after both halves are present.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Coefficient count, period and filter period.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			coef_cnt_r <= COEF_CNT_RST;
			period_r <= TRIG_W'(TRIG_PERIOD_RST);
			wake_filt_r <= WAKE_FILT_RST;
		end else if (wr_fire && wr_ok) begin
			if (wr_idx == COEF_CNT_IDX)
				coef_cnt_r <= w_data_r[COEF_CNT_W-1:0];
			if (wr_idx == TRIG_PERIOD_IDX)
				period_r <= w_data_r[TRIG_W-1:0];
			if (wr_idx == WAKE_FILT_IDX)
				wake_filt_r <= w_data_r[7:0];
		end
	end

	// Write-only mask; it stands until the next mask write.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= '0;
		end else if (wr_fire && wr_ok && wr_idx == CHOP_MASK_IDX) begin
			mask_r <= w_data_r[5:0];
		end
	end

	// Chopper control; each field only updates where its mask is set.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chop_r <= '{HOLD_RST, IIR_RST, FAST_RST};
		end else if (wr_fire && wr_ok && wr_idx == CHOP_CTRL_IDX) begin
			if (mask_r[5:4] == 2'h3)
				chop_r.swap_hold_time <= w_data_r[HOLD_LSB+:2];
			if (mask_r[3:1] == 3'h7)
				chop_r.iir_coefficient_select <= w_data_r[IIR_LSB+:3];
			if (mask_r[0])
				chop_r.amp_fast_mode <= w_data_r[FAST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Result capture
	// ----------------------------------------------------------------
	// A whole sample is latched at once so both halves agree.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_res_r <= '0;
			voltage_result_r <= '0;
		end else if (sample_in.valid) begin
			cur_res_r <= sample_in.current_result;
			voltage_result_r <= sample_in.voltage_result;
		end
	end

	// ----------------------------------------------------------------
	// Low-power trigger
	// ----------------------------------------------------------------
	// Counter runs up on each low-power tick and wraps at the period.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_cnt_r <= '0;
		end else if (!lowpower_mode) begin
			trig_cnt_r <= '0;
		end else if (lowpower_clock) begin
			if (trig_cnt_r == period_r)
				trig_cnt_r <= '0;
			else
				trig_cnt_r <= trig_cnt_r + 1'b1;
		end
	end

	// Start pulse on match; period zero matches every tick.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			start_r <= 1'b0;
		end else begin
			start_r <= lowpower_mode && lowpower_clock &&
				(trig_cnt_r == period_r);
		end
	end

	// Count of starts for software visibility.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			start_cnt_r <= '0;
		else if (start_r)
			start_cnt_r <= start_cnt_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rd_idx;
	logic rd_ok;
	logic [31:0] rd_data;
	assign rd_idx = idx_of(s_axi_araddr);

	// Read decode, no width check; result high places return bits 23:16, mask and control read zero, status packs count and flags, the rest zero-extended.
	always_comb begin
		rd_ok = 1'b1;
		rd_data = '0;
		case (rd_idx)
			RES_HI_WIDE_IDX, RES_HI_IDX:
				rd_data = {24'h0, cur_res_r[23:16]};
			RES_LO_IDX:
				rd_data = {16'h0, lo_snap_r};
			VOLTAGE_RESULT_IDX: rd_data = {16'h0, voltage_result_r};
			COEF_CNT_IDX: rd_data = {28'h0, coef_cnt_r};
			TRIG_PERIOD_IDX: rd_data = 32'(period_r);
			WAKE_FILT_IDX: rd_data = {24'h0, wake_filt_r};
			CHOP_MASK_IDX: rd_data = '0;
			CHOP_CTRL_IDX: rd_data = {26'h0, chop_r};
			CTRL_IDX: rd_data = '0;
			STATUS_IDX: rd_data = {8'h0, start_cnt_r,
				7'h0, lowpower_mode, 7'h0, byte_err_r};
			default: rd_ok = 1'b0;
		endcase
	end

	// Reading the high byte freezes the low word of the same sample.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lo_snap_r <= '0;
		end else if (s_axi_arvalid && s_axi_arready &&
				(rd_idx == RES_HI_IDX || rd_idx == RES_HI_WIDE_IDX)) begin
			lo_snap_r <= cur_res_r[15:0];
		end
	end

	// Sticky flag for period write attempts with an illegal width.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			byte_err_r <= 1'b0;
		else if (wr_fire && !wr_ok && wr_idx == TRIG_PERIOD_IDX)
			byte_err_r <= 1'b1;
		else if (wr_fire && wr_ok && wr_idx == CTRL_IDX && w_data_r[0])
			byte_err_r <= 1'b0;
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid &&
				!(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			filter_coefficient_count <= COEF_CNT_RST;
			threshold_wakeup_filter_period <= WAKE_FILT_RST;
			chopper_ctrl <= '{HOLD_RST, IIR_RST, FAST_RST};
			swap_hold_periods <= '0;
			acquisition_start <= 1'b0;
		end else begin
			filter_coefficient_count <= coef_cnt_r;
			threshold_wakeup_filter_period <= wake_filt_r;
			chopper_ctrl <= chop_r;
			swap_hold_periods <= hold_periods(chop_r.swap_hold_time);
			acquisition_start <= start_r;
		end
	end

endmodule

//--- acquisition_result_register_bank_properties.sv
// Concurrent checks on the ports of the acquisition register bank.
module acquisition_result_register_bank_properties
	import acq_regs_pkg::*;
#(
	parameter int TRIG_W = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Bus handshakes.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Trigger and chopper side.
	input wire logic lowpower_clock,
	input wire logic lowpower_mode,
	input wire chopper_ctrl_t chopper_ctrl,
	input wire logic [2:0] swap_hold_periods,
	input wire logic acquisition_start
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Bus sequences
	// ----------------------------------------------------------------
	// Address and data taken at one edge.
	sequence write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Period write whose strobe does not cover both low bytes.
	sequence narrow_period_write;
		write_taken ##0 (s_axi_awaddr[9:2] == TRIG_PERIOD_IDX)
			##0 (s_axi_wstrb[1:0] != 2'h3);
	endsequence
	// Read address taken.
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
		else $error("read response late");
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	chk_period_narrow: assert property (
		narrow_period_write |-> ##2 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("narrow period write accepted");
	chk_mask_reads_zero: assert property (
		read_taken ##0 (s_axi_araddr[9:2] == CHOP_MASK_IDX)
		|=> s_axi_rdata == 32'h0000_0000)
		else $error("mask read not zero");
	chk_start_cause: assert property (acquisition_start
		|-> $past(lowpower_clock, 2) && $past(lowpower_mode, 2))
		else $error("start without tick in low power");
	chk_no_start_idle: assert property (
		(!lowpower_mode)[*3] |-> !acquisition_start)
		else $error("start outside low power");
	chk_hold_map: assert property (($stable(chopper_ctrl))[*2]
		|-> swap_hold_periods == (
		(chopper_ctrl.swap_hold_time == 2'h0) ? 3'h0 :
		(chopper_ctrl.swap_hold_time == 2'h1) ? 3'h3 :
		(chopper_ctrl.swap_hold_time == 2'h2) ? 3'h4 : 3'h5))
		else $error("hold period mapping wrong");
endmodule

bind acquisition_result_register_bank
	acquisition_result_register_bank_properties #(.TRIG_W(TRIG_W)) u_chk (.*);

//--- acquisition_result_register_bank_test.sv
// Self-checking bench for the acquisition register bank.
module acquisition_result_register_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import acq_regs_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	sample_t sample_in = '0;
	logic lowpower_clock = 0, lowpower_mode = 0;
	logic [COEF_CNT_W-1:0] filter_coefficient_count;
	logic [7:0] threshold_wakeup_filter_period;
	chopper_ctrl_t chopper_ctrl;
	logic [2:0] swap_hold_periods;
	logic acquisition_start;
	int err_count = 0, check_count = 0, starts = 0;
	logic [31:0] d;
	logic [1:0] r;

	acquisition_result_register_bank #(.TRIG_W(16)) u_dut (.*);

	// Free-running core clock.
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// Counts acquisition start pulses.
	always @(posedge core_clk) begin
		if (acquisition_start === 1'b1) begin
			starts++;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic end_of_test;
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One write; address and data offered together, each released alone.
	task automatic wr(input logic [7:0] i, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic a, w;
		a = 0;
		w = 0;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge core_clk);
			if (!a && s_axi_awready === 1'b1) begin
				a = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask

	// One read; the answer is taken at the edge where rvalid is seen.
	task automatic rd(input logic [7:0] i, output logic [31:0] v,
		output logic [1:0] rs);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask

	// Sends low-power clock ticks four core cycles apart.
	task automatic tick(input int n);
		repeat (n) begin
			lowpower_clock <= 1'b1;
			@(posedge core_clk);
			lowpower_clock <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values of coefficient count, period, chopper mask and chopper control.
	task automatic t_reset;
		rd(COEF_CNT_IDX, d, r);
		chk(d, 32'h0000_000E);
		rd(TRIG_PERIOD_IDX, d, r);
		chk(d, 32'h0000_0000);
		rd(CHOP_MASK_IDX, d, r);
		chk(d, 32'h0000_0000);
		rd(CHOP_CTRL_IDX, d, r);
		chk(d, 32'h0000_000F);
		chk(filter_coefficient_count, 32'h0000_000E);
	endtask

	// Read/write fields, period strobe width and an unmapped place.
	task automatic t_regs;
		wr(COEF_CNT_IDX, 32'h0000_0003, 4'hF, r);
		repeat (2) @(posedge core_clk);
		chk(filter_coefficient_count, 32'h0000_0003);
		wr(TRIG_PERIOD_IDX, 32'h0000_BEEF, 4'h3, r);
		chk(r, RESP_OKAY);
		wr(TRIG_PERIOD_IDX, 32'h0000_0011, 4'h1, r);
		chk(r, RESP_SLVERR);
		rd(TRIG_PERIOD_IDX, d, r);
		chk(d, 32'h0000_BEEF);
		rd(STATUS_IDX, d, r);
		chk(d, 32'h0000_0001);
		wr(CTRL_IDX, 32'h0000_0001, 4'hF, r);
		rd(STATUS_IDX, d, r);
		chk(d, 32'h0000_0000);
		wr(WAKE_FILT_IDX, 32'h0000_00A5, 4'hF, r);
		repeat (2) @(posedge core_clk);
		chk(threshold_wakeup_filter_period, 32'h0000_00A5);
		rd(8'h40, d, r);
		chk({d[31:2], r}, {30'h0, RESP_SLVERR});
		wr(TRIG_PERIOD_IDX, 32'h0000_0000, 4'h3, r);
	endtask

	// Result reads with a fresh sample landing between high and low.
	task automatic t_sample;
		sample_in <= {1'b1, 24'h8ABCDE, 16'h1234};
		@(posedge core_clk);
		sample_in <= '0;
		rd(RES_HI_WIDE_IDX, d, r);
		chk(d[7:0], 32'h0000_008A);
		rd(RES_HI_IDX, d, r);
		chk(d[7:0], 32'h0000_008A);
		sample_in <= {1'b1, 24'h012345, 16'hF678};
		@(posedge core_clk);
		sample_in <= '0;
		rd(RES_LO_IDX, d, r);
		chk(d[15:0], 32'h0000_BCDE);
		rd(VOLTAGE_RESULT_IDX, d, r);
		chk(d[15:0], 32'h0000_F678);
		rd(RES_HI_IDX, d, r);
		rd(RES_LO_IDX, d, r);
		chk(d[15:0], 32'h0000_2345);
	endtask

	// Masked chopper writes and the hold-time mapping.
	task automatic t_chopper;
		logic [2:0] hp [4];
		hp = '{3'h0, 3'h3, 3'h4, 3'h5};
		wr(CHOP_MASK_IDX, 32'h0000_0000, 4'hF, r);
		wr(CHOP_CTRL_IDX, 32'h0000_0000, 4'hF, r);
		rd(CHOP_CTRL_IDX, d, r);
		chk(d, 32'h0000_000F);
		wr(CHOP_MASK_IDX, 32'h0000_003F, 4'hF, r);
		for (int h = 0; h < 4; h++) begin
			wr(CHOP_CTRL_IDX, {26'h0, h[1:0], 3'h2, 1'b1}, 4'hF, r);
			repeat (2) @(posedge core_clk);
			chk(chopper_ctrl, {26'h0, h[1:0], 3'h2, 1'b1});
			chk(swap_hold_periods, hp[h]);
		end
		wr(CHOP_MASK_IDX, 32'h0000_0001, 4'hF, r);
		wr(CHOP_CTRL_IDX, 32'h0000_0000, 4'hF, r);
		rd(CHOP_CTRL_IDX, d, r);
		chk(d, 32'h0000_0034);
		wr(CHOP_MASK_IDX, 32'h0000_000E, 4'hF, r);
		wr(CHOP_CTRL_IDX, 32'h0000_000F, 4'hF, r);
		rd(CHOP_CTRL_IDX, d, r);
		chk(d, 32'h0000_003E);
		rd(CHOP_MASK_IDX, d, r);
		chk(d, 32'h0000_0000);
	endtask

	// Continuous and cyclic triggering, then leaving low power.
	task automatic t_trigger;
		int s0;
		lowpower_mode <= 1'b1;
		s0 = starts;
		tick(4);
		chk(starts - s0, 4);
		wr(TRIG_PERIOD_IDX, 32'h0000_0002, 4'h3, r);
		s0 = starts;
		tick(9);
		chk(starts - s0, 3);
		lowpower_mode <= 1'b0;
		s0 = starts;
		tick(3);
		chk(starts - s0, 0);
		rd(STATUS_IDX, d, r);
		chk(d, 32'h0007_0000);
	endtask

	// Watchdog against a hung handshake.
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		end_of_test;
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_regs;
		t_sample;
		t_chopper;
		t_trigger;
		end_of_test;
	end
endmodule
